// ===== pbs_pkg.sv
// Package with offsets, field layouts, reset values and types of the power budget bank
package pbs_pkg;

  // Bus geometry
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int NUM_VALUES = 8;
  localparam int IDX_W = 3;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFF_DATA_SELECT = 12'h284;
  localparam logic [ADR_W-1:0] OFF_DATA_PORT = 12'h288;
  localparam logic [ADR_W-1:0] OFF_CAPABILITY = 12'h28C;
  localparam logic [ADR_W-1:0] OFF_VALUE_BASE = 12'h300;
  localparam logic [ADR_W-1:0] OFF_VALUE_LAST = 12'h31C;
  localparam logic [ADR_W-1:0] OFF_SWITCH_STATUS = 12'h400;
  localparam logic [ADR_W-1:0] OFF_SYSTEM_CONTROL = 12'h408;

  // Field positions
  localparam int FLAG_BIT = 0;
  localparam int UNLOCK_BIT = 0;
  localparam int SELECT_W = 8;
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_RSVD_BIT = 4;
  localparam int STATUS_CCLK_BIT = 5;
  localparam int MODE_W = 4;

  // Values after reset, highest valid select and full byte enable
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_UNLOCK = 1'b0;
  localparam logic [SELECT_W-1:0] RST_SELECT = 8'h00;
  localparam logic [DAT_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [SELECT_W-1:0] SELECT_MAX = 8'h07;
  localparam logic [SEL_W-1:0] SEL_ALL = 4'hF;

  // Switch mode codes
  localparam logic [MODE_W-1:0] MODE_NORMAL = 4'h0;
  localparam logic [MODE_W-1:0] MODE_NORMAL_EE = 4'h1;
  localparam logic [MODE_W-1:0] MODE_FAIL_P0 = 4'h8;
  localparam logic [MODE_W-1:0] MODE_FAIL_P2 = 4'h9;
  localparam logic [MODE_W-1:0] MODE_FAIL_EE_P0 = 4'hA;
  localparam logic [MODE_W-1:0] MODE_FAIL_EE_P2 = 4'hB;

  // Strap values latched at the end of fundamental reset
  typedef struct packed {
    logic cclk_ds;
    logic [MODE_W-1:0] op_mode;
  } pbs_strap_t;

  localparam pbs_strap_t RST_STRAP = '0;

  // Decoded operating mode
  typedef struct packed {
    logic reserved;
    logic eeprom_init;
    logic failover;
    logic upstream_port2;
  } pbs_mode_t;

  localparam pbs_mode_t RST_MODE = '0;

  // Classifies a switch mode code
  function automatic pbs_mode_t pbs_decode_mode(input logic [MODE_W-1:0] code);
    pbs_mode_t m;
    m = '0;
    case (code)
      MODE_NORMAL: m = '0;
      MODE_NORMAL_EE: m.eeprom_init = 1'b1;
      MODE_FAIL_P0: m.failover = 1'b1;
      MODE_FAIL_P2:
      begin
        m.failover = 1'b1;
        m.upstream_port2 = 1'b1;
      end
      MODE_FAIL_EE_P0:
      begin
        m.failover = 1'b1;
        m.eeprom_init = 1'b1;
      end
      MODE_FAIL_EE_P2:
      begin
        m.failover = 1'b1;
        m.eeprom_init = 1'b1;
        m.upstream_port2 = 1'b1;
      end
      default: m.reserved = 1'b1;
    endcase
    return m;
  endfunction

  // Merges write data into a word under byte enables
  function automatic logic [DAT_W-1:0] pbs_merge(input logic [DAT_W-1:0] old_w,
                                                 input logic [DAT_W-1:0] new_w,
                                                 input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] r;
    r = old_w;
    for (int b = 0; b < SEL_W; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ===== pbs_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pbs_sync
  import pbs_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else if (ce_i)
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// ===== pbs_strap_latch.sv
// Strap capture held from the end of fundamental reset onward
`timescale 1ns/1ps
module pbs_strap_latch
  import pbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic fund_rst_act_i,
  input wire pbs_strap_t strap_i,
  output pbs_strap_t strap_o
);

  pbs_strap_t strap_r;
  pbs_strap_t strap_nxt;

  // Track straps during fundamental reset, freeze at its release
  assign strap_nxt = fund_rst_act_i ? strap_i : strap_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_r <= RST_STRAP;
    end
    else if (ce_i)
    begin
      strap_r <= strap_nxt;
    end
  end

  assign strap_o = strap_r;

endmodule

// ===== pbs_regs.sv
// Power budget and switch status register bank with a Wishbone slave port
// Functional notes
// - System allocated flag, bit 0, resets zero
// - Eight sticky 32-bit budget values, no reset
// - Unlock set: budget values readable and writable
// - Unlock clear: budget value writes discarded
// - Status bits 3:0 show latched mode pins
// - Modes 0,1 normal; 2..7 reserved
// - Modes 8..B failover; C..F reserved
// - Bit 5 common clock strap; bit 4 zero
// - Data port returns selected value, else zero
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module pbs_regs
  import pbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fundamental_reset_n_i,
  input wire logic [MODE_W-1:0] switch_op_mode_i,
  input wire logic common_clock_downstream_i,
  output pbs_mode_t switch_mode_o,
  output logic system_allocated_o,
  output logic budget_value_unlock_o
);

  logic fund_rst_n_s;
  logic fund_rst_act;
  pbs_strap_t strap_raw;
  pbs_strap_t strap_s;
  pbs_strap_t status_q;
  logic ack_r;
  logic [DAT_W-1:0] rdat_r;
  logic [DAT_W-1:0] rdat_nxt;
  logic alloc_r;
  logic unlock_r;
  logic [SELECT_W-1:0] dsel_r;
  logic [DAT_W-1:0] value_mem [NUM_VALUES];
  pbs_mode_t mode_r;

  // Fundamental reset pin, synchronised
  pbs_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(fundamental_reset_n_i),
    .sync_o(fund_rst_n_s)
  );

  // Strap pins, synchronised
  assign strap_raw = {common_clock_downstream_i, switch_op_mode_i};

  pbs_sync #(.WIDTH($bits(pbs_strap_t)), .RST_VAL(RST_STRAP)) u_strap_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(strap_raw),
    .sync_o(strap_s)
  );

  assign fund_rst_act = ~fund_rst_n_s;

  pbs_strap_latch u_strap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .fund_rst_act_i(fund_rst_act),
    .strap_i(strap_s),
    .strap_o(status_q)
  );

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire req_new = req & ~ack_r;
  wire wr_fire = req & ack_r & wb_we_i;
  wire hit_dsel = (wb_adr_i[ADR_W-1:2] == OFF_DATA_SELECT[ADR_W-1:2]);
  wire hit_dport = (wb_adr_i[ADR_W-1:2] == OFF_DATA_PORT[ADR_W-1:2]);
  wire hit_cap = (wb_adr_i[ADR_W-1:2] == OFF_CAPABILITY[ADR_W-1:2]);
  wire hit_val = (wb_adr_i[ADR_W-1:2] >= OFF_VALUE_BASE[ADR_W-1:2]) &&
                 (wb_adr_i[ADR_W-1:2] <= OFF_VALUE_LAST[ADR_W-1:2]);
  wire hit_stat = (wb_adr_i[ADR_W-1:2] == OFF_SWITCH_STATUS[ADR_W-1:2]);
  wire hit_ctl = (wb_adr_i[ADR_W-1:2] == OFF_SYSTEM_CONTROL[ADR_W-1:2]);
  wire [IDX_W-1:0] val_idx = wb_adr_i[IDX_W+1:2];
  wire [IDX_W-1:0] dsel_idx = dsel_r[IDX_W-1:0];
  wire dsel_ok = (dsel_r <= SELECT_MAX);

  // Read views of each register
  wire [DAT_W-1:0] cap_word = {{(DAT_W-1){1'b0}}, alloc_r};
  wire [DAT_W-1:0] ctl_word = {{(DAT_W-1){1'b0}}, unlock_r};
  wire [DAT_W-1:0] dsel_word = {{(DAT_W-SELECT_W){1'b0}}, dsel_r};
  wire [DAT_W-1:0] dport_word = dsel_ok ? value_mem[dsel_idx] : RST_WORD;
  wire [DAT_W-1:0] stat_word = {{(DAT_W-6){1'b0}}, status_q.cclk_ds, 1'b0,
                                status_q.op_mode};

  // Read data mux; unmapped reads return zero
  always_comb
  begin
    rdat_nxt = RST_WORD;
    if (hit_dsel)
    begin
      rdat_nxt = dsel_word;
    end
    else if (hit_dport)
    begin
      rdat_nxt = dport_word;
    end
    else if (hit_cap)
    begin
      rdat_nxt = cap_word;
    end
    else if (hit_val)
    begin
      rdat_nxt = value_mem[val_idx];
    end
    else if (hit_stat)
    begin
      rdat_nxt = stat_word;
    end
    else if (hit_ctl)
    begin
      rdat_nxt = ctl_word;
    end
  end

  // Write enables; status register has none
  wire we_dsel = wr_fire & hit_dsel;
  wire we_cap = wr_fire & hit_cap & unlock_r;
  wire we_val = wr_fire & hit_val & unlock_r;
  wire we_ctl = wr_fire & hit_ctl;
  wire [DAT_W-1:0] cap_new = pbs_merge(cap_word, wb_dat_i, wb_sel_i);
  wire [DAT_W-1:0] ctl_new = pbs_merge(ctl_word, wb_dat_i, wb_sel_i);
  wire [DAT_W-1:0] dsel_new = pbs_merge(dsel_word, wb_dat_i, wb_sel_i);
  wire [DAT_W-1:0] val_new = pbs_merge(value_mem[val_idx], wb_dat_i, wb_sel_i);

  // Acknowledge one cycle after the request, read data alongside
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rdat_r <= RST_WORD;
    end
    else if (ce_i)
    begin
      ack_r <= req_new;
      rdat_r <= req_new ? rdat_nxt : RST_WORD;
    end
  end

  // Control registers, cleared by either reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && fund_rst_act))
    begin
      alloc_r <= RST_FLAG;
      unlock_r <= RST_UNLOCK;
      dsel_r <= RST_SELECT;
    end
    else if (ce_i)
    begin
      if (we_cap)
      begin
        alloc_r <= cap_new[FLAG_BIT];
      end
      if (we_ctl)
      begin
        unlock_r <= ctl_new[UNLOCK_BIT];
      end
      if (we_dsel)
      begin
        dsel_r <= dsel_new[SELECT_W-1:0];
      end
    end
  end

  // Budget values keep their contents across every reset
  always_ff @(posedge clk_i)
  begin
    if (ce_i && !rst_i && we_val)
    begin
      value_mem[val_idx] <= val_new;
    end
  end

  // Registered mode decode of the latched straps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= RST_MODE;
    end
    else if (ce_i)
    begin
      mode_r <= pbs_decode_mode(status_q.op_mode);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign switch_mode_o = mode_r;
  assign system_allocated_o = alloc_r;
  assign budget_value_unlock_o = unlock_r;

  // Checks
  property p_flag_reset;
    @(posedge clk_i) rst_i |=> !alloc_r;
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("flag not cleared by reset");

  property p_sticky;
    @(posedge clk_i) disable iff (!ce_i)
      rst_i |=> (value_mem[0] === $past(value_mem[0]));
  endproperty
  a_sticky: assert property (p_sticky) else $error("budget value lost on reset");

  property p_write_unlocked;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (wr_fire && hit_val && unlock_r && wb_sel_i == SEL_ALL)
      |=> (value_mem[$past(val_idx)] == $past(wb_dat_i));
  endproperty
  a_write_unlocked: assert property (p_write_unlocked) else $error("unlocked write lost");

  property p_write_locked;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (wr_fire && hit_val && !unlock_r)
      |=> (value_mem[$past(val_idx)] == $past(value_mem[val_idx]));
  endproperty
  a_write_locked: assert property (p_write_locked) else $error("locked write took effect");

  property p_status_read;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (req_new && !wb_we_i && hit_stat)
      |=> (wb_ack_o && wb_dat_o[STATUS_RSVD_BIT] == 1'b0 &&
           wb_dat_o[STATUS_CCLK_BIT] == $past(status_q.cclk_ds) &&
           wb_dat_o[3:0] == $past(status_q.op_mode));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_mode_reserved;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      ##1 (mode_r.reserved == (($past(status_q.op_mode) inside {[4'h2:4'h7]}) ||
                               ($past(status_q.op_mode) >= 4'hC)));
  endproperty
  a_mode_reserved: assert property (p_mode_reserved) else $error("reserved decode");

  property p_mode_failover;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      ##1 (mode_r.failover == ($past(status_q.op_mode) inside {[4'h8:4'hB]}));
  endproperty
  a_mode_failover: assert property (p_mode_failover) else $error("failover decode");

  property p_dport_zero;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (req_new && !wb_we_i && hit_dport && !dsel_ok) |=> (wb_dat_o == RST_WORD);
  endproperty
  a_dport_zero: assert property (p_dport_zero) else $error("data port not zero");

  property p_status_frozen;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (!fund_rst_act && $past(!fund_rst_act)) |-> $stable(status_q);
  endproperty
  a_status_frozen: assert property (p_status_frozen) else $error("status moved");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");

  property p_ack_follows;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      req_new |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");

  property p_value_read;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (req_new && !wb_we_i && hit_val) |=> (wb_dat_o == $past(value_mem[val_idx]));
  endproperty
  a_value_read: assert property (p_value_read) else $error("budget value read wrong");

  property p_dport_value;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (req_new && !wb_we_i && hit_dport && dsel_ok)
      |=> (wb_dat_o == $past(value_mem[dsel_idx]));
  endproperty
  a_dport_value: assert property (p_dport_value) else $error("data port value wrong");

  property p_cap_locked;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (wr_fire && hit_cap && !unlock_r && !fund_rst_act) |=> $stable(alloc_r);
  endproperty
  a_cap_locked: assert property (p_cap_locked) else $error("flag written while locked");

  c_unlocked_write: cover property (@(posedge clk_i) we_val);
  c_locked_write: cover property (@(posedge clk_i) wr_fire && hit_val && !unlock_r);
  c_dport_read: cover property (@(posedge clk_i) req_new && hit_dport && dsel_ok);
  c_strap_release: cover property (@(posedge clk_i) $rose(fund_rst_n_s));
  c_reserved_mode: cover property (@(posedge clk_i) mode_r.reserved);

endmodule

// ===== pbs_regs_tb_top.sv
// Self-checking testbench for the power budget and switch status register bank
`timescale 1ns/1ps
module pbs_regs_tb_top import pbs_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat_w;
  logic ack;
  logic fund_n = 1'b0;
  logic [MODE_W-1:0] mode_pin = '0;
  logic cclk_pin = 1'b0;
  pbs_mode_t mode_o;
  logic alloc_o, unlock_o;
  logic [DAT_W-1:0] exp_v [NUM_VALUES];
  logic [DAT_W-1:0] d;
  int n_mismatch = 0;
  int total_checks = 0;

  pbs_regs i_pbs_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat_w), .wb_ack_o(ack), .fundamental_reset_n_i(fund_n),
    .switch_op_mode_i(mode_pin), .common_clock_downstream_i(cclk_pin),
    .switch_mode_o(mode_o), .system_allocated_o(alloc_o), .budget_value_unlock_o(unlock_o));

  // Clock at 100 ns period
  always #50 clk_i = ~clk_i;

  // Compares a value and counts the result
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [SEL_W-1:0] s,
                      input logic [DAT_W-1:0] v, output logic [DAT_W-1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= v;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 50)
      chk("ack wait", 32'h1, 32'h0);
    r = rdat_w;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] v);
    xfer(1'b1, a, SEL_ALL, v, d);
  endtask

  task automatic rdchk(input string nm, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
    xfer(1'b0, a, SEL_ALL, '0, d);
    chk(nm, e, d);
  endtask

  // Fundamental reset pulse with new strap values
  task automatic fund(input logic [MODE_W-1:0] m, input logic c);
    @(posedge clk_i);
    fund_n <= 1'b0;
    mode_pin <= m;
    cclk_pin <= c;
    repeat (8) @(posedge clk_i);
    fund_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  // Expected mode decode {reserved, eeprom_init, failover, upstream_port2}
  function automatic logic [3:0] exp_mode(input logic [3:0] c);
    logic fo, ee, p2;
    fo = (c >= 4'h8) && (c <= 4'hB);
    ee = (c == 4'h1) || (c == 4'hA) || (c == 4'hB);
    p2 = (c == 4'h9) || (c == 4'hB);
    return {!(fo || c <= 4'h1), ee, fo, p2};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog against a hung bus
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    fund(4'h1, 1'b1);
    rdchk("capability", OFF_CAPABILITY, 32'h0);
    chk("flag out", 32'h0, {31'h0, alloc_o});
    wr(OFF_CAPABILITY, 32'h1);
    rdchk("capability locked", OFF_CAPABILITY, 32'h0);
    wr(OFF_SYSTEM_CONTROL, 32'h1);
    // Unlock output updates at the edge that completes the write
    @(posedge clk_i);
    chk("unlock out", 32'h1, {31'h0, unlock_o});
    // Initial load of every value, as the boot loader would, then read back
    for (int i = 0; i < NUM_VALUES; i++)
    begin
      exp_v[i] = 32'h5A00_0000 ^ (i * 32'h0101_0011);
      wr(OFF_VALUE_BASE + 12'(4 * i), exp_v[i]);
    end
    for (int i = 0; i < NUM_VALUES; i++)
      rdchk("value", OFF_VALUE_BASE + 12'(4 * i), exp_v[i]);
    xfer(1'b1, OFF_VALUE_BASE, 4'h2, 32'hFFFF_FFFF, d);
    exp_v[0][15:8] = 8'hFF;
    rdchk("value byte lane", OFF_VALUE_BASE, exp_v[0]);
    wr(OFF_CAPABILITY, 32'hFFFF_FFFF);
    rdchk("capability set", OFF_CAPABILITY, 32'h1);
    chk("flag out set", 32'h1, {31'h0, alloc_o});
    // Data port through every select plus out-of-range ones
    for (int s = 0; s < 11; s++)
    begin
      wr(OFF_DATA_SELECT, (s == 10) ? 32'hFF : 32'(s));
      rdchk("data port", OFF_DATA_PORT, (s < 8) ? exp_v[s] : 32'h0);
    end
    // Locked writes are discarded
    wr(OFF_SYSTEM_CONTROL, 32'h0);
    for (int i = 0; i < NUM_VALUES; i++)
      wr(OFF_VALUE_BASE + 12'(4 * i), ~exp_v[i]);
    for (int i = 0; i < NUM_VALUES; i++)
      rdchk("value locked", OFF_VALUE_BASE + 12'(4 * i), exp_v[i]);
    // Values survive a fundamental reset, the flag does not
    fund(4'h0, 1'b0);
    rdchk("value sticky", OFF_VALUE_BASE + 12'h01C, exp_v[7]);
    rdchk("capability after fund", OFF_CAPABILITY, 32'h0);
    // Every mode code and both strap levels
    for (int m = 0; m < 16; m++)
    begin
      fund(4'(m), m[0]);
      rdchk("status", OFF_SWITCH_STATUS, {26'h0, m[0], 1'b0, 4'(m)});
      chk("mode decode", {28'h0, exp_mode(4'(m))}, {28'h0, mode_o});
    end
    // Straps frozen after release, status unwritable
    mode_pin <= 4'h5;
    cclk_pin <= 1'b0;
    repeat (6) @(posedge clk_i);
    wr(OFF_SWITCH_STATUS, 32'h0000_0000);
    rdchk("status frozen", OFF_SWITCH_STATUS, 32'h0000_002F);
    chk("mode frozen", {28'h0, exp_mode(4'hF)}, {28'h0, mode_o});
    rdchk("unmapped", 12'h500, 32'h0);
    rdchk("unmapped gap", 12'h404, 32'h0);
    close_out();
  end
endmodule
